// ===== rtl/bth_config_header.sv
// Bridge type 1 configuration header register bank with APB slave
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module bth_config_header
#(
  parameter logic [7:0] REV_RESET = 8'h00 // Arbitrary revision value
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bridge events
  input  wire logic        err_msg_sent,
  input  wire logic        poisoned_tlp_rx,
  // Bus numbering towards routing
  output logic      [7:0]  primary_bus_number,
  output logic      [7:0]  secondary_bus_number,
  output logic      [7:0]  subordinate_bus_number,
  // Interrupt
  output logic             irq
);

  // State
  logic       system_error_report_enable;
  logic       signalled_system_error_flag;
  logic       detected_parity_error_flag;
  logic [7:0] revision_number;
  logic [7:0] cache_line_size;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic       unlock;

  // Address decode
  wire logic [9:0] idx        = paddr[11:2];
  wire logic       sel_cmd    = (idx == bth_pkg::IDX_CMD);
  wire logic       sel_sts    = (idx == bth_pkg::IDX_STS);
  wire logic       sel_rev    = (idx == bth_pkg::IDX_REV);
  wire logic       sel_cc     = (idx == bth_pkg::IDX_DEVICE_CLASS_CODE);
  wire logic       sel_cls    = (idx == bth_pkg::IDX_CLS);
  wire logic       sel_plt    = (idx == bth_pkg::IDX_PLT);
  wire logic       sel_hdr    = (idx == bth_pkg::IDX_HDR);
  wire logic       sel_st     = (idx == bth_pkg::IDX_SELFTEST);
  wire logic       sel_base0  = (idx == bth_pkg::IDX_BASE0);
  wire logic       sel_base1  = (idx == bth_pkg::IDX_BASE1);
  wire logic       sel_pbus   = (idx == bth_pkg::IDX_PBUS);
  wire logic       sel_sbus   = (idx == bth_pkg::IDX_SBUS);
  wire logic       sel_subus  = (idx == bth_pkg::IDX_SUBUS);
  wire logic       sel_ists   = (idx == bth_pkg::IDX_IRQ_STS);
  wire logic       sel_imask  = (idx == bth_pkg::IDX_IRQ_MASK);
  wire logic       sel_unlock = (idx == bth_pkg::IDX_UNLOCK);
  wire logic       mapped     = sel_cmd | sel_sts | sel_rev | sel_cc | sel_cls | sel_plt
                              | sel_hdr | sel_st | sel_base0 | sel_base1 | sel_pbus
                              | sel_sbus | sel_subus | sel_ists | sel_imask | sel_unlock;

  // Bus phases
  wire logic setup  = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr_en  = access & pwrite & mapped;

  // Write strobes per register; read-only words get none
  wire logic wr_cmd    = wr_en & sel_cmd;
  wire logic wr_sts    = wr_en & sel_sts;
  wire logic wr_rev    = wr_en & sel_rev & unlock;
  wire logic wr_cls    = wr_en & sel_cls;
  wire logic wr_pbus   = wr_en & sel_pbus;
  wire logic wr_sbus   = wr_en & sel_sbus;
  wire logic wr_subus  = wr_en & sel_subus;
  wire logic wr_ists   = wr_en & sel_ists;
  wire logic wr_imask  = wr_en & sel_imask;
  wire logic wr_unlock = wr_en & sel_unlock;

  // Flag set and clear terms; set wins over clear
  wire logic set_sse = err_msg_sent & system_error_report_enable;
  wire logic clr_sse = wr_sts & pwdata[bth_pkg::STS_SSE_BIT];
  wire logic set_dpe = poisoned_tlp_rx;
  wire logic clr_dpe = wr_sts & pwdata[bth_pkg::STS_DPE_BIT];
  wire logic next_sse = set_sse | (signalled_system_error_flag & ~clr_sse);
  wire logic next_dpe = set_dpe | (detected_parity_error_flag & ~clr_dpe);

  wire logic [1:0] irq_events = {set_dpe, set_sse};
  wire logic [1:0] irq_clr    = wr_ists ? pwdata[1:0] : 2'h0;
  wire logic [1:0] next_irq_status = irq_events | (irq_status & ~irq_clr);

  // Read words; status 12 and 13 stay zero
  wire logic [31:0] cmd_word = {23'h0, system_error_report_enable, 8'h00};
  wire logic [31:0] sts_word = {16'h0000, detected_parity_error_flag,
                                signalled_system_error_flag, 2'b00, 12'h000};
  wire logic [31:0] cc_word  = {8'h00, bth_pkg::CC_BASECLASS, bth_pkg::CC_SUBCLASS,
                                bth_pkg::CC_PROG_IF};

  // Read data selection
  wire logic [31:0] rd_word =
      ({32{sel_cmd}}    & cmd_word)
    | ({32{sel_sts}}    & sts_word)
    | ({32{sel_rev}}    & {24'h0, revision_number})
    | ({32{sel_cc}}     & cc_word)
    | ({32{sel_cls}}    & {24'h0, cache_line_size})
    | ({32{sel_plt}}    & {24'h0, bth_pkg::PLT_VALUE})
    | ({32{sel_hdr}}    & {24'h0, bth_pkg::HDR_VALUE})
    | ({32{sel_st}}     & {24'h0, bth_pkg::SELFTEST_VAL})
    | ({32{sel_base0}}  & bth_pkg::BASE_VALUE)
    | ({32{sel_base1}}  & bth_pkg::BASE_VALUE)
    | ({32{sel_pbus}}   & {24'h0, primary_bus_number})
    | ({32{sel_sbus}}   & {24'h0, secondary_bus_number})
    | ({32{sel_subus}}  & {24'h0, subordinate_bus_number})
    | ({32{sel_ists}}   & {30'h0, irq_status})
    | ({32{sel_imask}}  & {30'h0, irq_mask})
    | ({32{sel_unlock}} & {31'h0, unlock});

  // Zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign irq     = |(irq_status & irq_mask);

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_word;
  end

  // Error flags
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      signalled_system_error_flag <= bth_pkg::FLAG_RESET;
      detected_parity_error_flag  <= bth_pkg::FLAG_RESET;
      irq_status                  <= bth_pkg::IRQ_RESET;
    end
    else
    begin
      signalled_system_error_flag <= next_sse;
      detected_parity_error_flag  <= next_dpe;
      irq_status                  <= next_irq_status;
    end
  end

  // Command enable, mask and lock
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      system_error_report_enable <= bth_pkg::SYSTEM_ERROR_REPORT_ENABLE_RESET;
      irq_mask                   <= bth_pkg::IRQ_RESET;
      unlock                     <= bth_pkg::UNLOCK_RESET;
    end
    else
    begin
      if (wr_cmd)
        system_error_report_enable <= pwdata[bth_pkg::CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT];
      if (wr_imask)
        irq_mask <= pwdata[1:0];
      if (wr_unlock)
        unlock <= pwdata[bth_pkg::UNLOCK_BIT];
    end
  end

  // Plain storage bytes
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      revision_number        <= REV_RESET;
      cache_line_size        <= bth_pkg::CLS_RESET;
      primary_bus_number     <= bth_pkg::BUS_RESET;
      secondary_bus_number   <= bth_pkg::BUS_RESET;
      subordinate_bus_number <= bth_pkg::BUS_RESET;
    end
    else
    begin
      if (wr_rev)
        revision_number <= pwdata[7:0];
      if (wr_cls)
        cache_line_size <= pwdata[7:0];
      if (wr_pbus)
        primary_bus_number <= pwdata[7:0];
      if (wr_sbus)
        secondary_bus_number <= pwdata[7:0];
      if (wr_subus)
        subordinate_bus_number <= pwdata[7:0];
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_sse_set;
    err_msg_sent && system_error_report_enable |=> signalled_system_error_flag;
  endproperty
  a_sse_set: assert property (p_sse_set)
    else $error("system error flag not set by error message");

  property p_sse_needs_enable;
    !signalled_system_error_flag && !system_error_report_enable
      |=> !signalled_system_error_flag;
  endproperty
  a_sse_needs_enable: assert property (p_sse_needs_enable)
    else $error("system error flag set while reporting disabled");

  property p_dpe_set;
    poisoned_tlp_rx |=> detected_parity_error_flag ##1 (detected_parity_error_flag || $past(clr_dpe));
  endproperty
  a_dpe_set: assert property (p_dpe_set)
    else $error("parity flag not set by poisoned packet");

  property p_dpe_clear;
    detected_parity_error_flag && clr_dpe && !poisoned_tlp_rx |=> !detected_parity_error_flag;
  endproperty
  a_dpe_clear: assert property (p_dpe_clear)
    else $error("parity flag not cleared by written one");

  property p_abort_zero;
    setup && sel_sts && !pwrite |=> prdata[13:12] == 2'b00 && prdata[31:16] == 16'h0000;
  endproperty
  a_abort_zero: assert property (p_abort_zero)
    else $error("abort status bits read nonzero");

  property p_rev_locked;
    !unlock |=> $stable(revision_number);
  endproperty
  a_rev_locked: assert property (p_rev_locked)
    else $error("revision changed while locked");

  property p_class_code;
    setup && sel_cc && !pwrite |=> prdata == 32'h0006_0400;
  endproperty
  a_class_code: assert property (p_class_code)
    else $error("class code read wrong");

  property p_cls_write;
    wr_en && sel_cls |=> cache_line_size == $past(pwdata[7:0]);
  endproperty
  a_cls_write: assert property (p_cls_write)
    else $error("cache line size write lost");

  property p_fixed_bytes;
    setup && !pwrite && (sel_plt || sel_st || sel_base0 || sel_base1) |=> prdata == 32'h0;
  endproperty
  a_fixed_bytes: assert property (p_fixed_bytes)
    else $error("zero field read nonzero");

  property p_header_type;
    setup && sel_hdr && !pwrite |=> prdata == 32'h0000_0001;
  endproperty
  a_header_type: assert property (p_header_type)
    else $error("header type read wrong");

  property p_bus_numbers;
    wr_en && (sel_pbus || sel_sbus || sel_subus) |=>
      (primary_bus_number == $past(pwdata[7:0]) || !$past(sel_pbus))
      && (secondary_bus_number == $past(pwdata[7:0]) || !$past(sel_sbus))
      && (subordinate_bus_number == $past(pwdata[7:0]) || !$past(sel_subus));
  endproperty
  a_bus_numbers: assert property (p_bus_numbers)
    else $error("bus number write lost");

  property p_system_error_report_enable_write;
    wr_cmd |=> system_error_report_enable == $past(pwdata[8]);
  endproperty
  a_system_error_report_enable_write: assert property (p_system_error_report_enable_write)
    else $error("error report enable write lost");

  property p_zero_write_keeps;
    signalled_system_error_flag && wr_sts && !pwdata[14] |=> signalled_system_error_flag;
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("flag cleared by a written zero");

  property p_irq_raise;
    poisoned_tlp_rx && irq_mask[1] && !wr_imask |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("unmasked event did not raise interrupt");

  property p_sse_clear;
    signalled_system_error_flag && clr_sse && !set_sse |=> !signalled_system_error_flag;
  endproperty
  a_sse_clear: assert property (p_sse_clear)
    else $error("system error flag not cleared by written one");

  property p_rev_write;
    wr_rev |=> revision_number == $past(pwdata[7:0]);
  endproperty
  a_rev_write: assert property (p_rev_write)
    else $error("revision write lost while unlocked");

  property p_cls_hold;
    !wr_cls |=> $stable(cache_line_size);
  endproperty
  a_cls_hold: assert property (p_cls_hold)
    else $error("cache line size changed without a write");

  property p_pbus_hold;
    !wr_pbus |=> $stable(primary_bus_number);
  endproperty
  a_pbus_hold: assert property (p_pbus_hold)
    else $error("primary bus number changed without a write");

  property p_subus_write;
    wr_subus |=> subordinate_bus_number == $past(pwdata[7:0]);
  endproperty
  a_subus_write: assert property (p_subus_write)
    else $error("subordinate bus number write lost");

  property p_dpe_zero_write;
    detected_parity_error_flag && wr_sts && !pwdata[bth_pkg::STS_DPE_BIT]
      |=> detected_parity_error_flag;
  endproperty
  a_dpe_zero_write: assert property (p_dpe_zero_write)
    else $error("parity flag cleared by a written zero");

  property p_system_error_report_enable_hold;
    !wr_cmd |=> $stable(system_error_report_enable);
  endproperty
  a_system_error_report_enable_hold: assert property (p_system_error_report_enable_hold)
    else $error("error report enable changed without a write");

  property p_irq_sse_event;
    set_sse |=> irq_status[bth_pkg::IRQ_SSE_BIT];
  endproperty
  a_irq_sse_event: assert property (p_irq_sse_event)
    else $error("system error event not recorded for interrupt");

  c_sse_set:   cover property (set_sse ##1 signalled_system_error_flag);
  c_dpe_clear: cover property (detected_parity_error_flag ##1 clr_dpe ##1 !detected_parity_error_flag);
  c_irq:       cover property (!irq ##1 irq);
  c_rev_write: cover property (wr_rev);

endmodule

`default_nettype wire

// ===== rtl/bth_pkg.sv
// Constants of the bridge type 1 configuration header register bank
package bth_pkg;

  // Word index of each register; byte address is four times the index
  localparam logic [9:0] IDX_CMD      = 10'h004;
  localparam logic [9:0] IDX_STS      = 10'h006;
  localparam logic [9:0] IDX_REV      = 10'h008;
  localparam logic [9:0] IDX_DEVICE_CLASS_CODE    = 10'h009;
  localparam logic [9:0] IDX_CLS      = 10'h00c;
  localparam logic [9:0] IDX_PLT      = 10'h00d;
  localparam logic [9:0] IDX_HDR      = 10'h00e;
  localparam logic [9:0] IDX_SELFTEST = 10'h00f;
  localparam logic [9:0] IDX_BASE0    = 10'h010;
  localparam logic [9:0] IDX_BASE1    = 10'h014;
  localparam logic [9:0] IDX_PBUS     = 10'h018;
  localparam logic [9:0] IDX_SBUS     = 10'h019;
  localparam logic [9:0] IDX_SUBUS    = 10'h01a;
  localparam logic [9:0] IDX_IRQ_STS  = 10'h020;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h021;
  localparam logic [9:0] IDX_UNLOCK   = 10'h022;

  // Field positions
  localparam int CMD_SYSTEM_ERROR_REPORT_ENABLE_BIT  = 8;
  localparam int STS_RTA_BIT    = 12;
  localparam int STS_RMA_BIT    = 13;
  localparam int STS_SSE_BIT    = 14;
  localparam int STS_DPE_BIT    = 15;
  localparam int IRQ_SSE_BIT    = 0;
  localparam int IRQ_DPE_BIT    = 1;
  localparam int UNLOCK_BIT     = 0;

  // Fixed read values
  localparam logic [7:0]  CC_PROG_IF   = 8'h00;
  localparam logic [7:0]  CC_SUBCLASS  = 8'h04;
  localparam logic [7:0]  CC_BASECLASS = 8'h06;
  localparam logic [7:0]  PLT_VALUE    = 8'h00;
  localparam logic [7:0]  HDR_VALUE    = 8'h01;
  localparam logic [7:0]  SELFTEST_VAL = 8'h00;
  localparam logic [31:0] BASE_VALUE   = 32'h0000_0000;

  // Reset values
  localparam logic [7:0] CLS_RESET    = 8'h00;
  localparam logic [7:0] BUS_RESET    = 8'h00;
  localparam logic       SYSTEM_ERROR_REPORT_ENABLE_RESET  = 1'b0;
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic [1:0] IRQ_RESET    = 2'h0;
  localparam logic       UNLOCK_RESET = 1'b0;

endpackage

// ===== tb/bth_cfg_host.sv
// Configuration host model: APB master that issues single register transfers
`timescale 1ns/10ps
`default_nettype none

module bth_cfg_host
(
  // Clock
  input  wire logic        sys_clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer: setup, access until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00}; // Byte address is four times the word index
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;  // Released lines must not keep a stale value
    pwdata  <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking testbench of the bridge configuration header bank
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [7:0] REV_INIT = 8'h3c; // Arbitrary revision value

  typedef struct {logic [9:0] i; logic [31:0] r; logic [31:0] d; logic [31:0] e; logic ee;} bth_row_t;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        err_msg_sent = 1'b0;
  logic        poisoned_tlp_rx = 1'b0;
  wire  logic        psel, penable, pwrite, pready, pslverr, irq;
  wire  logic [11:0] paddr;
  wire  logic [31:0] pwdata, prdata;
  wire  logic [7:0]  pbus, sbus, subus;
  int          errors = 0;
  int          cmp_count = 0;
  bth_row_t    rows [$];

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  bth_config_header #(.REV_RESET(REV_INIT)) u_bth_config_header (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_msg_sent(err_msg_sent), .poisoned_tlp_rx(poisoned_tlp_rx),
    .primary_bus_number(pbus), .secondary_bus_number(sbus),
    .subordinate_bus_number(subus), .irq(irq));

  bth_cfg_host u_bth_cfg_host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access with checks of read data and error response
  task automatic acc(input logic w, input logic [9:0] i, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic        er;
    u_bth_cfg_host.xfer(w, i, d, r, er);
    if (!w) cmp(r, e);
    cmp({31'h0, er}, {31'h0, ee});
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    acc(1'b1, i, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0, e, 1'b0);
  endtask

  // One-cycle event pulses
  task automatic pulse(input logic sys_err, input logic poison);
    @(posedge sys_clk);
    err_msg_sent    <= sys_err;
    poisoned_tlp_rx <= poison;
    @(posedge sys_clk);
    err_msg_sent    <= 1'b0;
    poisoned_tlp_rx <= 1'b0;
  endtask

  // Interrupt level, looked at mid-cycle once the last write has settled
  task automatic chk_irq(input logic e);
    @(negedge sys_clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h1, 32'h0);
    end_of_test();
  end

  // Rows: index, reset value, written value, value read back, error expected
  initial
  begin
    rows = '{
      '{bth_pkg::IDX_DEVICE_CLASS_CODE,    32'h0006_0400, 32'hffff_ffff, 32'h0006_0400, 1'b0},
      '{bth_pkg::IDX_REV,      {24'h0, REV_INIT}, 32'h0000_00a7, {24'h0, REV_INIT}, 1'b0},
      '{bth_pkg::IDX_CLS,      32'h0, 32'hffff_ff5a, 32'h0000_005a, 1'b0},
      '{bth_pkg::IDX_PLT,      32'h0, 32'h0000_00ff, 32'h0, 1'b0},
      '{bth_pkg::IDX_HDR,      32'h1, 32'h0000_00fe, 32'h1, 1'b0},
      '{bth_pkg::IDX_SELFTEST, 32'h0, 32'h0000_00ff, 32'h0, 1'b0},
      '{bth_pkg::IDX_BASE0,    32'h0, 32'hffff_ffff, 32'h0, 1'b0},
      '{bth_pkg::IDX_BASE1,    32'h0, 32'hffff_ffff, 32'h0, 1'b0},
      '{bth_pkg::IDX_PBUS,     32'h0, 32'h0000_0011, 32'h0000_0011, 1'b0},
      '{bth_pkg::IDX_SBUS,     32'h0, 32'h0000_0022, 32'h0000_0022, 1'b0},
      '{bth_pkg::IDX_SUBUS,    32'h0, 32'h0000_0033, 32'h0000_0033, 1'b0},
      '{bth_pkg::IDX_CMD,      32'h0, 32'h0000_0100, 32'h0000_0100, 1'b0},
      '{bth_pkg::IDX_STS,      32'h0, 32'hffff_ffff, 32'h0, 1'b0},
      '{bth_pkg::IDX_IRQ_MASK, 32'h0, 32'hffff_ffff, 32'h3, 1'b0},
      '{bth_pkg::IDX_UNLOCK,   32'h0, 32'h0000_0001, 32'h1, 1'b0},
      '{10'h3ff,               32'h0, 32'h0000_0001, 32'h0, 1'b1}};
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    // Table: reset value, write, read back
    foreach (rows[k])
    begin
      acc(1'b0, rows[k].i, 32'h0, rows[k].r, rows[k].ee);
      acc(1'b1, rows[k].i, rows[k].d, 32'h0, rows[k].ee);
      acc(1'b0, rows[k].i, 32'h0, rows[k].e, rows[k].ee);
    end
    cmp({8'h0, pbus, sbus, subus}, 32'h0011_2233);
    wr(bth_pkg::IDX_REV, 32'h0000_00a7);
    rd(bth_pkg::IDX_REV, 32'h0000_00a7);
    $display("test table done");
    // Error message ignored while report enable is off
    wr(bth_pkg::IDX_CMD, 32'h0);
    wr(bth_pkg::IDX_IRQ_MASK, 32'h0);
    pulse(1'b1, 1'b0);
    rd(bth_pkg::IDX_STS, 32'h0);
    rd(bth_pkg::IDX_IRQ_STS, 32'h0);
    // Poisoned packet sets its flag regardless of enables
    pulse(1'b0, 1'b1);
    rd(bth_pkg::IDX_STS, 32'h0000_8000);
    chk_irq(1'b0);
    wr(bth_pkg::IDX_IRQ_MASK, 32'h2);
    chk_irq(1'b1);
    wr(bth_pkg::IDX_STS, 32'h0);
    rd(bth_pkg::IDX_STS, 32'h0000_8000);
    wr(bth_pkg::IDX_STS, 32'h0000_8000);
    rd(bth_pkg::IDX_STS, 32'h0);
    wr(bth_pkg::IDX_IRQ_STS, 32'h2);
    chk_irq(1'b0);
    $display("test poisoned done");
    // Error message sets its flag with report enable on
    wr(bth_pkg::IDX_CMD, 32'h0000_0100);
    pulse(1'b1, 1'b0);
    rd(bth_pkg::IDX_STS, 32'h0000_4000);
    wr(bth_pkg::IDX_STS, 32'h0000_3000);
    rd(bth_pkg::IDX_STS, 32'h0000_4000);
    rd(bth_pkg::IDX_IRQ_STS, 32'h1);
    wr(bth_pkg::IDX_IRQ_MASK, 32'h1);
    chk_irq(1'b1);
    wr(bth_pkg::IDX_STS, 32'h0000_4000);
    rd(bth_pkg::IDX_STS, 32'h0);
    wr(bth_pkg::IDX_IRQ_STS, 32'h1);
    chk_irq(1'b0);
    $display("test system error done");
    // Reset in mid-run restores reset values
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    cmp({8'h0, pbus, sbus, subus}, 32'h0);
    rd(bth_pkg::IDX_CLS, 32'h0);
    rd(bth_pkg::IDX_REV, {24'h0, REV_INIT});
    rd(bth_pkg::IDX_CMD, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
